/* File: rfc_pkg.sv */
// rfc_pkg: register map, field positions, reset values and state types of the receive buffer unit.
// assumes byte addressing on a 32-bit apb bus, one register per aligned word.
package rfc_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RFC_COMMAND_OFS    = 8'h00;
	localparam logic [7:0] RFC_IRQ_EN_OFS     = 8'h04;
	localparam logic [7:0] RFC_IRQ_FLAGS_OFS  = 8'h08;
	localparam logic [7:0] RFC_AUX_FLAGS_OFS  = 8'h0c;
	localparam logic [7:0] RFC_ERROR_OFS      = 8'h10;
	localparam logic [7:0] RFC_STATUS_OFS     = 8'h14;
	localparam logic [7:0] RFC_DATA_OFS       = 8'h18;
	localparam logic [7:0] RFC_LEVEL_OFS      = 8'h1c;
	localparam logic [7:0] RFC_WATERMARK_OFS  = 8'h20;
	localparam logic [7:0] RFC_MODE_OFS       = 8'h24;
	localparam logic [7:0] RFC_CRC_HI_OFS     = 8'h28;
	localparam logic [7:0] RFC_CRC_LO_OFS     = 8'h2c;
	localparam logic [7:0] RFC_LEN_MIN_OFS    = 8'h30;
	localparam logic [7:0] RFC_LEN_MAX_OFS    = 8'h34;
	localparam logic [7:0] RFC_CRC_START_OFS  = 8'h38;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RFC_IRQ_TIMER   = 0;
	localparam int RFC_IRQ_ERR     = 1;
	localparam int RFC_IRQ_AE      = 2;
	localparam int RFC_IRQ_AF      = 3;
	localparam int RFC_IRQ_CMD     = 4;
	localparam int RFC_IRQ_RX      = 5;
	localparam int RFC_IRQ_TX      = 6;
	localparam int RFC_IRQ_EN_CRC  = 7;
	localparam int RFC_AUX_CRC     = 2;
	localparam int RFC_ERR_OVF     = 4;
	localparam int RFC_ST_AE       = 0;
	localparam int RFC_ST_AF       = 1;
	localparam int RFC_ST_IRQ      = 4;
	localparam int RFC_ST_CRC_RDY  = 5;
	localparam int RFC_LVL_FLUSH   = 7;
	localparam int RFC_MODE_MSB    = 5;
	localparam int RFC_CRC_GO      = 0;

	// ----------------------------------------------------------------
	// constants and reset values
	// ----------------------------------------------------------------
	localparam int          RFC_DEPTH      = 64;
	localparam logic [6:0]  RFC_FULL_CNT   = 7'h40;
	localparam logic [8:0]  RFC_MAX_UNLIM  = 9'h100;
	localparam logic [3:0]  RFC_CMD_IDLE   = 4'h0;
	localparam logic [15:0] RFC_POLY_MSB   = 16'h1021;
	localparam logic [15:0] RFC_POLY_LSB   = 16'h8408;
	localparam logic [15:0] RFC_PRESET_0   = 16'h0000;
	localparam logic [15:0] RFC_PRESET_1   = 16'h6363;
	localparam logic [15:0] RFC_PRESET_2   = 16'ha671;
	localparam logic [15:0] RFC_PRESET_3   = 16'hffff;
	localparam logic [31:0] RFC_RD_ZERO    = 32'h0000_0000;

	typedef enum logic {
		RFC_CRC_IDLE,
		RFC_CRC_RUN
	} rfc_crc_st_t;

endpackage : rfc_pkg

/* File: rfc_unit.sv */
// rfc_unit: 64-byte shared buffer with length filter, crc coprocessor, alerts and interrupt flags.
// assumes the receiver, transmitter, timer and sequencer run on pclk and drive one-cycle event pulses.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// RQ1: accept packet only if length byte >= four times six-bit minimum setting.
// RQ2: accept only length below four times maximum setting; zero means limit 256.
// RQ3: rejected packet never enters buffer; receiver stays active for next packet.
// RQ4: crc preset chosen by two-bit select: 0000h, 6363h, A671h, FFFFh.
// RQ5: crc is 16-bit with polynomial x^16 + x^12 + x^5 + 1.
// RQ6: bit-order control set feeds bytes msb first, else lsb first.
// RQ7: crc drains buffer, then sets ready and done flag; result as two bytes.
// RQ8: one buffer of 64 bytes shared by host and internal logic.
// RQ9: host write to data port stores byte at write pointer and advances it.
// RQ10: host read of data port returns byte at read pointer and consumes it.
// RQ11: read-only seven-bit level shows number of stored bytes.
// RQ12: host keeps off the buffer while a command uses it.
// RQ13: flush resets pointers, zeroes level and clears overflow.
// RQ14: overflow stays set until a flush; nothing else clears it.
// RQ15: almost-full set when 64 minus count is at most the watermark.
// RQ16: almost-empty set when count is at most the watermark.
// RQ17: enabled alert rising to one raises the interrupt pin.
// RQ18: alert flags set when the matching alert bit becomes one.
// RQ19: timer flag set when timer counts from 1 to 0.
// RQ20: tx flag on start of end-of-frame; rx flag at end of received data.
// RQ21: command flag set when command completes and field returns to idle.
// RQ22: error flag set whenever any error status bit is one.
// RQ23: byte arriving at full buffer is lost and sets overflow.
// RQ24: flags stay set until host clears; pin is OR of enabled flags.
module rfc_unit (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// receive stream
	input  wire logic         rx_valid,
	input  wire logic         rx_first,
	input  wire logic [7:0]   rx_data,
	input  wire logic         rx_end,
	// internal reader of the buffer
	input  wire logic         sm_pop_req,
	output logic [7:0]        sm_pop_data,
	output logic              sm_pop_valid,
	// sequencer, transmitter, timer and error events
	input  wire logic         cmd_finish,
	input  wire logic         tx_eof_start,
	input  wire logic         timer_one_to_zero,
	input  wire logic [7:0]   err_in,
	output logic [3:0]        cmd_code,
	// interrupt pin
	output logic              irq
);
	import rfc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RFC_DEPTH-1:0][7:0] mem;
		logic [5:0]                wr_ptr;
		logic [5:0]                rd_ptr;
		logic [6:0]                count;
		logic                      ovf;
		logic [3:0]                cmd;
		logic [7:0]                irq_en;
		logic [6:0]                flags;
		logic                      crc_flag;
		logic [5:0]                wm;
		logic [1:0]                crc_sel;
		logic                      crc_msb;
		logic [5:0]                len_min;
		logic [5:0]                len_max;
		logic [15:0]               crc;
		logic                      crc_ready;
		rfc_crc_st_t               crc_st;
		logic                      rx_pass;
		logic                      af;
		logic                      ae;
		logic                      irq;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
		logic [7:0]                pop_data;
		logic                      pop_valid;
	} rfc_state_t;

	rfc_state_t st_reg;
	rfc_state_t st_next;

	// one byte through the crc, both bit orders
	function automatic logic [15:0] rfc_crc_byte(input logic [15:0] c, input logic [7:0] d, input logic msb);
		logic [15:0] v;
		v = c;
		if (msb) begin
			v = v ^ {d, 8'h00};
			for (int i = 0; i < 8; i++) begin
				v = v[15] ? ((v << 1) ^ RFC_POLY_MSB) : (v << 1);
			end
		end else begin
			v = v ^ {8'h00, d};
			for (int i = 0; i < 8; i++) begin
				v = v[0] ? ((v >> 1) ^ RFC_POLY_LSB) : (v >> 1);
			end
		end
		return v;
	endfunction : rfc_crc_byte

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic        hit;
	logic [31:0] rd_val;
	logic        acc;
	logic        done;
	logic        wr;
	logic        rd;
	logic        push;
	logic [7:0]  push_data;
	logic        pop;
	logic        crc_pop;
	logic        host_pop;
	logic        len_ok;
	logic [8:0]  max_lim;
	logic [7:0]  err_val;
	logic [6:0]  set;
	logic [6:0]  clr;
	logic [7:0]  head;
	logic        lost;

	always_comb begin
		st_next   = st_reg;
		hit       = 1'b1;
		rd_val    = RFC_RD_ZERO;
		push      = 1'b0;
		push_data = rx_data;
		pop       = 1'b0;
		crc_pop   = 1'b0;
		set       = '0;
		clr       = '0;
		lost      = 1'b0;
		head      = st_reg.mem[st_reg.rd_ptr];
		err_val   = err_in;
		err_val[RFC_ERR_OVF] = st_reg.ovf;

		// apb decode
		if (paddr == RFC_COMMAND_OFS) begin
			rd_val[3:0] = st_reg.cmd;
		end else if (paddr == RFC_IRQ_EN_OFS) begin
			rd_val[7:0] = st_reg.irq_en;
		end else if (paddr == RFC_IRQ_FLAGS_OFS) begin
			rd_val[6:0] = st_reg.flags;
		end else if (paddr == RFC_AUX_FLAGS_OFS) begin
			rd_val[RFC_AUX_CRC] = st_reg.crc_flag;
		end else if (paddr == RFC_ERROR_OFS) begin
			rd_val[7:0] = err_val;
		end else if (paddr == RFC_STATUS_OFS) begin
			rd_val[RFC_ST_AE]      = st_reg.ae;
			rd_val[RFC_ST_AF]      = st_reg.af;
			rd_val[RFC_ST_IRQ]     = st_reg.irq;
			rd_val[RFC_ST_CRC_RDY] = st_reg.crc_ready;
		end else if (paddr == RFC_DATA_OFS) begin
			// empty buffer reads as zero and consumes nothing
			rd_val[7:0] = (st_reg.count != 7'h00) ? head : 8'h00;
		end else if (paddr == RFC_LEVEL_OFS) begin
			rd_val[6:0] = st_reg.count;
		end else if (paddr == RFC_WATERMARK_OFS) begin
			rd_val[5:0] = st_reg.wm;
		end else if (paddr == RFC_MODE_OFS) begin
			rd_val[1:0]          = st_reg.crc_sel;
			rd_val[RFC_MODE_MSB] = st_reg.crc_msb;
		end else if (paddr == RFC_CRC_HI_OFS) begin
			rd_val[7:0] = st_reg.crc[15:8];
		end else if (paddr == RFC_CRC_LO_OFS) begin
			rd_val[7:0] = st_reg.crc[7:0];
		end else if (paddr == RFC_LEN_MIN_OFS) begin
			rd_val[5:0] = st_reg.len_min;
		end else if (paddr == RFC_LEN_MAX_OFS) begin
			rd_val[5:0] = st_reg.len_max;
		end else if (paddr == RFC_CRC_START_OFS) begin
			rd_val = RFC_RD_ZERO;
		end else begin
			hit = 1'b0;
		end

		// one wait cycle: answer is prepared, then the transfer completes
		acc               = psel & penable;
		done              = acc & st_reg.pready;
		st_next.pready    = acc & ~st_reg.pready;
		st_next.pslverr   = acc & ~st_reg.pready & ~hit;
		st_next.prdata    = (acc & ~st_reg.pready & ~pwrite) ? rd_val : RFC_RD_ZERO;
		wr                = done & pwrite & hit;
		rd                = done & ~pwrite & hit;

		// configuration writes
		if (wr && paddr == RFC_COMMAND_OFS) begin
			st_next.cmd = pwdata[3:0];
		end
		if (wr && paddr == RFC_IRQ_EN_OFS) begin
			st_next.irq_en = pwdata[7:0];
		end
		if (wr && paddr == RFC_WATERMARK_OFS) begin
			st_next.wm = pwdata[5:0];
		end
		if (wr && paddr == RFC_MODE_OFS) begin
			st_next.crc_sel = pwdata[1:0];
			st_next.crc_msb = pwdata[RFC_MODE_MSB];
		end
		if (wr && paddr == RFC_LEN_MIN_OFS) begin
			st_next.len_min = pwdata[5:0];
		end
		if (wr && paddr == RFC_LEN_MAX_OFS) begin
			st_next.len_max = pwdata[5:0];
		end

		// RQ1 minimum length check
		// RQ2 maximum length, zero is 256
		max_lim = (st_reg.len_max == 6'h00) ? RFC_MAX_UNLIM : {1'b0, st_reg.len_max, 2'b00};
		len_ok  = (rx_data >= {st_reg.len_min, 2'b00}) && ({1'b0, rx_data} < max_lim);

		// RQ3 drop rejected packet, keep receiving
		if (rx_valid) begin
			if (rx_first) begin
				st_next.rx_pass = len_ok;
				push            = len_ok;
			end else begin
				push = st_reg.rx_pass;
			end
		end
		if (rx_end) begin
			st_next.rx_pass = 1'b0;
		end

		// RQ9 host write pushes; the receive stream has priority
		if (!push && wr && paddr == RFC_DATA_OFS) begin
			push      = 1'b1;
			push_data = pwdata[7:0];
		end

		// RQ10 host read consumes the head byte
		host_pop = rd && paddr == RFC_DATA_OFS && st_reg.count != 7'h00;

		// RQ7 crc drains the buffer one byte a cycle
		case (st_reg.crc_st)
			RFC_CRC_IDLE: begin
				if (wr && paddr == RFC_CRC_START_OFS && pwdata[RFC_CRC_GO]) begin
					// RQ4 preset selection
					case (st_reg.crc_sel)
						2'd0: st_next.crc = RFC_PRESET_0;
						2'd1: st_next.crc = RFC_PRESET_1;
						2'd2: st_next.crc = RFC_PRESET_2;
						default: st_next.crc = RFC_PRESET_3;
					endcase
					st_next.crc_ready = 1'b0;
					st_next.crc_st    = RFC_CRC_RUN;
				end
			end
			RFC_CRC_RUN: begin
				if (st_reg.count == 7'h00) begin
					st_next.crc_ready = 1'b1;
					st_next.crc_flag  = 1'b1;
					st_next.crc_st    = RFC_CRC_IDLE;
				end else if (!host_pop) begin
					crc_pop = 1'b1;
					// RQ5 RQ6 polynomial and bit order
					st_next.crc = rfc_crc_byte(st_reg.crc, head, st_reg.crc_msb);
				end
			end
			default: st_next.crc_st = RFC_CRC_IDLE;
		endcase

		// internal reader gets the head when nobody else pops
		pop                  = host_pop | crc_pop;
		st_next.pop_valid    = 1'b0;
		if (!pop && sm_pop_req && st_reg.count != 7'h00) begin
			pop                  = 1'b1;
			st_next.pop_valid    = 1'b1;
			st_next.pop_data     = head;
		end

		// RQ8 shared 64-byte buffer
		// RQ23 byte at full buffer is lost
		// host and receiver bytes alike are lost at full and flag overflow
		if (push && st_reg.count == RFC_FULL_CNT) begin
			push = 1'b0;
			lost = 1'b1;
		end
		if (push) begin
			st_next.mem[st_reg.wr_ptr] = push_data;
			st_next.wr_ptr             = st_reg.wr_ptr + 6'd1;
		end
		if (pop) begin
			st_next.rd_ptr = st_reg.rd_ptr + 6'd1;
		end
		// RQ11 level counts up on each push and down on each pop
		st_next.count = st_reg.count + {6'h00, push} - {6'h00, pop};

		// RQ13 flush resets pointers and level
		// RQ14 overflow cleared by flush only
		if (wr && paddr == RFC_LEVEL_OFS && pwdata[RFC_LVL_FLUSH]) begin
			st_next.wr_ptr = 6'h00;
			st_next.rd_ptr = 6'h00;
			st_next.count  = 7'h00;
			st_next.ovf    = 1'b0;
		end
		// a loss in the flush cycle still shows
		if (lost) begin
			st_next.ovf = 1'b1;
		end

		// RQ15 almost full
		// RQ16 almost empty
		st_next.af = (RFC_FULL_CNT - st_reg.count) <= {1'b0, st_reg.wm};
		st_next.ae = st_reg.count <= {1'b0, st_reg.wm};

		// RQ18 alert flags on rising alert
		set[RFC_IRQ_AF] = st_next.af & ~st_reg.af;
		set[RFC_IRQ_AE] = st_next.ae & ~st_reg.ae;
		// RQ19 timer flag
		set[RFC_IRQ_TIMER] = timer_one_to_zero;
		// RQ20 tx and rx done
		set[RFC_IRQ_TX] = tx_eof_start;
		set[RFC_IRQ_RX] = rx_end;
		// RQ21 command completes to idle
		if (cmd_finish) begin
			st_next.cmd     = RFC_CMD_IDLE;
			set[RFC_IRQ_CMD] = 1'b1;
		end
		// RQ22 any error bit raises the error flag
		set[RFC_IRQ_ERR] = (err_val != 8'h00);

		// RQ24 sticky flags, write one clears, set wins
		if (wr && paddr == RFC_IRQ_FLAGS_OFS) begin
			clr = pwdata[6:0];
		end
		st_next.flags = (st_reg.flags & ~clr) | set;
		if (wr && paddr == RFC_AUX_FLAGS_OFS && pwdata[RFC_AUX_CRC] && st_reg.crc_st != RFC_CRC_RUN) begin
			st_next.crc_flag = 1'b0;
		end

		// RQ17 RQ24 pin is or of enabled flags
		st_next.irq = |(st_next.flags & st_reg.irq_en[6:0]) | (st_next.crc_flag & st_reg.irq_en[RFC_IRQ_EN_CRC]);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata       = st_reg.prdata;
	assign pready       = st_reg.pready;
	assign pslverr      = st_reg.pslverr;
	assign sm_pop_data  = st_reg.pop_data;
	assign sm_pop_valid = st_reg.pop_valid;
	assign cmd_code     = st_reg.cmd;
	assign irq          = st_reg.irq;

endmodule : rfc_unit

/* File: rfc_unit_assertions.sv */
// rfc_unit_assertions: port checks of the apb slave, pop and command outputs.
// assumes binding to rfc_unit; sees its ports only.
`timescale 1ns/100ps
module rfc_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pop and command
	input wire logic        sm_pop_req,
	input wire logic        sm_pop_valid,
	input wire logic        cmd_finish,
	input wire logic [3:0]  cmd_code
);
	import rfc_pkg::*;
	logic [3:0] cmd_wr;
	assign cmd_wr = pwdata[3:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_after_access_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_zero_a: assert property (!pready |-> prdata == RFC_RD_ZERO)
		else $error("prdata not zero");
	unmapped_err_a: assert property (pready && paddr > RFC_CRC_START_OFS |-> pslverr)
		else $error("unmapped access not refused");
	pop_cause_a: assert property (sm_pop_valid |-> $past(sm_pop_req))
		else $error("pop without request");
	cmd_write_a: assert property (pready && psel && pwrite && paddr == RFC_COMMAND_OFS && !cmd_finish
		|=> cmd_code == $past(cmd_wr)) else $error("command write lost");
	cmd_idle_a: assert property (cmd_finish && !pready |=> cmd_code == RFC_CMD_IDLE)
		else $error("command not idle");
	cover property (pslverr);
	cover property (sm_pop_valid);
	cover property (cmd_finish);
endmodule : rfc_chk

bind rfc_unit rfc_chk u_rfc_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sm_pop_req(sm_pop_req), .sm_pop_valid(sm_pop_valid),
	.cmd_finish(cmd_finish), .cmd_code(cmd_code));

/* File: rfc_rx_source.sv */
// rfc_rx_source: behavioural receiver feeding packets into the rx stream.
// assumes the bench calls send() from one thread, one packet at a time.
`timescale 1ns/100ps
module rfc_rx_source (
	// clock
	input wire logic  pclk,
	// rx stream
	output logic       rx_valid,
	output logic       rx_first,
	output logic [7:0] rx_data,
	output logic       rx_end
);
	initial begin
		rx_valid = 1'b0;
		rx_first = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
	end
	task automatic send(input logic [7:0] len, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_first <= (i == 0);
			rx_data <= (i == 0) ? len : 8'ha0 + i[7:0];
			@(posedge pclk);
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			// idle byte flips so nothing leans on a held value
			rx_data <= ~rx_data;
			repeat (gap) @(posedge pclk);
		end
		@(posedge pclk);
		rx_end <= 1'b1;
		@(posedge pclk);
		rx_end <= 1'b0;
	endtask : send
endmodule : rfc_rx_source

/* File: rfc_unit_tb_top.sv */
// rfc_unit_tb_top: self-checking bench of the buffer unit over apb.
// assumes the rx source model and the bound checker are compiled too.
`timescale 1ns/100ps
module rfc_unit_tb_top;
	import rfc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, err_in = 8'h00, rx_data, sm_pop_data;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, serr, rx_valid, rx_first, rx_end, sm_pop_valid, irq;
	logic        sm_pop_req = 1'b0, cmd_finish = 1'b0, tx_eof_start = 1'b0, tmr = 1'b0;
	logic [3:0]  cmd_code;
	logic [15:0] crc;
	logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
	logic [7:0]  lens [4] = '{8'd16, 8'd19, 8'd20, 8'd15};
	int          acc [4] = '{3, 3, 0, 0};
	int          ev [4] = '{0, 1, 4, 6};
	int          err_total = 0, checked = 0, cyc = 0, n;

	rfc_unit u_rfc_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
		.rx_end(rx_end), .sm_pop_req(sm_pop_req), .sm_pop_data(sm_pop_data),
		.sm_pop_valid(sm_pop_valid), .cmd_finish(cmd_finish), .tx_eof_start(tx_eof_start),
		.timer_one_to_zero(tmr), .err_in(err_in), .cmd_code(cmd_code), .irq(irq));
	rfc_rx_source u_rfc_rx_source (.pclk(pclk), .rx_valid(rx_valid), .rx_first(rx_first),
		.rx_data(rx_data), .rx_end(rx_end));

	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("ERROR %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is seen high at a rising edge; only the bench timeout ends a wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rc
	task automatic pulse(input int k);
		@(posedge pclk);
		case (k)
			0: tmr <= 1'b1;
			1: err_in <= 8'h01;
			4: cmd_finish <= 1'b1;
			6: tx_eof_start <= 1'b1;
			default: sm_pop_req <= 1'b1;
		endcase
		@(posedge pclk);
		{tmr, cmd_finish, tx_eof_start, sm_pop_req} <= 4'h0;
		err_in <= 8'h00;
	endtask : pulse
	function automatic logic [15:0] crc_of(input logic [15:0] c, input logic msb, input logic [15:0] d);
		logic fb;
		for (int i = 15; i >= 0; i--) begin
			if (msb) begin
				fb = c[15] ^ d[i];
				c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
			end else begin
				fb = c[0] ^ d[(i / 8) * 8 + 7 - i % 8];
				c = {1'b0, c[15:1]} ^ (fb ? 16'h8408 : 16'h0000);
			end
		end
		return c;
	endfunction : crc_of

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rc(RFC_IRQ_FLAGS_OFS, 32'h04, '1);
		rc(RFC_STATUS_OFS, 32'h01, 32'h33);
		wr(RFC_IRQ_FLAGS_OFS, 32'h7f);
		rc(RFC_IRQ_FLAGS_OFS, 32'h00, '1);
		rc(8'h3c, 32'h00, '1);
		chk({31'h0, serr}, 32'h1);
		wr(RFC_WATERMARK_OFS, 32'h02);
		for (int i = 0; i < 3; i++) wr(RFC_DATA_OFS, 32'h10 + i);
		rc(RFC_LEVEL_OFS, 32'h03, '1);
		rc(RFC_STATUS_OFS, 32'h00, 32'h03);
		for (int i = 0; i < 3; i++) rc(RFC_DATA_OFS, 32'h10 + i, 32'hff);
		rc(RFC_IRQ_FLAGS_OFS, 32'h04, '1);
		wr(RFC_IRQ_FLAGS_OFS, 32'h7f);
		for (int i = 0; i < 64; i++) wr(RFC_DATA_OFS, i);
		rc(RFC_LEVEL_OFS, 32'h40, '1);
		rc(RFC_STATUS_OFS, 32'h02, 32'h03);
		rc(RFC_IRQ_FLAGS_OFS, 32'h08, '1);
		wr(RFC_IRQ_EN_OFS, 32'h08);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(RFC_DATA_OFS, 32'hee);
		rc(RFC_ERROR_OFS, 32'h10, 32'h10);
		rc(RFC_LEVEL_OFS, 32'h40, '1);
		rc(RFC_IRQ_FLAGS_OFS, 32'h02, 32'h02);
		wr(RFC_IRQ_FLAGS_OFS, 32'h08);
		wr(RFC_ERROR_OFS, '1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rc(RFC_ERROR_OFS, 32'h10, 32'h10);
		rc(RFC_DATA_OFS, 32'h00, 32'hff);
		wr(RFC_LEVEL_OFS, 32'h80);
		rc(RFC_LEVEL_OFS, 32'h00, '1);
		rc(RFC_ERROR_OFS, 32'h00, 32'h10);
		wr(RFC_IRQ_FLAGS_OFS, 32'h7f);
		wr(RFC_LEN_MIN_OFS, 32'h04);
		wr(RFC_LEN_MAX_OFS, 32'h05);
		n = 0;
		foreach (lens[k]) begin
			u_rfc_rx_source.send(lens[k], 3, k);
			n += acc[k];
			repeat (2) @(posedge pclk);
			rc(RFC_LEVEL_OFS, n, '1);
		end
		wr(RFC_LEN_MIN_OFS, 32'h09);
		wr(RFC_LEN_MAX_OFS, 32'h00);
		u_rfc_rx_source.send(8'd255, 2, 0);
		repeat (2) @(posedge pclk);
		rc(RFC_LEVEL_OFS, 32'h08, '1);
		rc(RFC_IRQ_FLAGS_OFS, 32'h20, 32'h20);
		wr(RFC_LEVEL_OFS, 32'h80);
		wr(RFC_COMMAND_OFS, 32'h05);
		@(posedge pclk);
		chk({28'h0, cmd_code}, 32'h5);
		wr(RFC_IRQ_EN_OFS, 32'h53);
		foreach (ev[k]) begin
			wr(RFC_IRQ_FLAGS_OFS, 32'h7f);
			pulse(ev[k]);
			repeat (2) @(posedge pclk);
			chk({31'h0, irq}, 32'h1);
			rc(RFC_IRQ_FLAGS_OFS, 32'h1 << ev[k], 32'h73);
		end
		chk({28'h0, cmd_code}, 32'h0);
		wr(RFC_IRQ_EN_OFS, 32'h00);
		wr(RFC_DATA_OFS, 32'h5a);
		pulse(8);
		@(posedge pclk);
		chk({23'h0, sm_pop_valid, sm_pop_data}, 32'h15a);
		pulse(8);
		@(posedge pclk);
		chk({31'h0, sm_pop_valid}, 32'h0);
		for (int p = 0; p < 8; p++) begin
			wr(RFC_DATA_OFS, 32'h12);
			wr(RFC_DATA_OFS, 32'h34);
			wr(RFC_MODE_OFS, {26'h0, p[0], 3'h0, p[2:1]});
			wr(RFC_CRC_START_OFS, 32'h01);
			n = 0;
			do begin
				apb(1'b0, RFC_STATUS_OFS, 32'h0);
				n++;
			end while (rd[5] !== 1'b1 && n < 30);
			crc = crc_of(pre[p[2:1]], p[0], 16'h1234);
			rc(RFC_CRC_HI_OFS, {24'h0, crc[15:8]}, 32'hff);
			rc(RFC_CRC_LO_OFS, {24'h0, crc[7:0]}, 32'hff);
			rc(RFC_AUX_FLAGS_OFS, 32'h04, 32'h04);
			rc(RFC_LEVEL_OFS, 32'h00, '1);
			wr(RFC_AUX_FLAGS_OFS, 32'h04);
		end
		end_of_test();
	end
endmodule : rfc_unit_tb_top
